// [verification/bcw_props.sv]
// checker: reset, routing and read-drive relations at the card pins
// assumes the board clock and power-on reset of the top module
`default_nettype none
module bcw_props (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// bus
	input wire logic       bus_wr_n,
	input wire logic       bus_rd_n,
	input wire logic       bus_sysreset_n,
	input wire logic [7:0] bus_rdata,
	input wire logic       bus_rdata_oe_n,
	input wire logic       bus_nmi_n,
	input wire logic       bus_pbreset_n,
	// jumpers and board outputs
	input wire logic       nonmaskable_route_jumper,
	input wire logic       pushbutton_route_jumper,
	input wire logic       dac_outputs_on_flag,
	input wire logic       board_reset_n,
	input wire logic       fault_lamp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_lamp_on: assert property ($fell(board_reset_n) |-> ##[0:2] fault_lamp)
		else $error("lamp dark during board reset");
	a_lamp_off: assert property (board_reset_n [*4] |-> !fault_lamp)
		else $error("lamp lit outside reset");
	a_oe_idle: assert property (bus_rd_n [*5] |-> bus_rdata_oe_n)
		else $error("data driven without a read");
	a_top_zero: assert property (!bus_rdata_oe_n |-> bus_rdata[7:5] == 3'h0)
		else $error("status top bits not zero");
	a_nmi_route: assert property (!bus_nmi_n |-> !nonmaskable_route_jumper)
		else $error("nmi without its jumper");
	a_pb_route: assert property (!bus_pbreset_n |-> !pushbutton_route_jumper)
		else $error("pushbutton reset without its jumper");
	a_nmi_held: assert property ($rose(bus_nmi_n) |-> ##[0:2] !board_reset_n)
		else $error("nmi released without reset");
	a_sys_reset: assert property ($fell(bus_sysreset_n) |-> ##[1:5] !board_reset_n)
		else $error("system reset not passed on");
	a_dac_cause: assert property ($changed(dac_outputs_on_flag) |->
		!bus_sysreset_n || !$past(bus_wr_n, 2) || !$past(bus_wr_n, 5))
		else $error("dac enable moved without a write");
endmodule
bind board_control_watchdog bcw_props u_bcw_props (
	.clk_sys, .rst_n, .bus_wr_n, .bus_rd_n, .bus_sysreset_n, .bus_rdata,
	.bus_rdata_oe_n, .bus_nmi_n, .bus_pbreset_n, .nonmaskable_route_jumper,
	.pushbutton_route_jumper, .dac_outputs_on_flag, .board_reset_n,
	.fault_lamp
);
`default_nettype wire

// [verification/board_control_watchdog_tb.sv]
// bench: card control block against a host model and a reference
// assumes short intervals of 20 and 40 ticks of 2 clocks
`default_nettype none
module board_control_watchdog_tb import board_ctl_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SH = 20, LG = 40, TK = 2;
	logic clk_sys, rst_n, bus_sysreset_n, io_window_polarity_jumper;
	logic interval_select_shunt, nonmaskable_route_jumper;
	logic pushbutton_route_jumper, single_polarity_flag, converter_busy_flag;
	logic low_power_standby, bus_iorq_n, bus_rd_n, bus_wr_n, bus_ioexp;
	logic bus_rdata_oe_n, bus_nmi_n, bus_pbreset_n, dac_outputs_on_flag;
	logic board_reset_n, fault_lamp;
	logic [3:0] base_select_jumper;
	logic [7:0] bus_addr, bus_wdata, bus_rdata;
	logic [8:0] q;
	int num_errors = 0, num_checks = 0, cyc_cnt = 0, dac_m, dog_m, ivl;
	board_control_watchdog #(.SHORT_TICKS_P(SH), .LONG_TICKS_P(LG),
		.TICK_CYCLES_P(TK)) u_board_control_watchdog (.clk_sys, .rst_n,
		.bus_addr, .bus_wdata, .bus_iorq_n, .bus_rd_n, .bus_wr_n, .bus_ioexp,
		.bus_sysreset_n, .bus_rdata, .bus_rdata_oe_n, .bus_nmi_n,
		.bus_pbreset_n, .base_select_jumper, .io_window_polarity_jumper,
		.interval_select_shunt, .nonmaskable_route_jumper,
		.pushbutton_route_jumper, .single_polarity_flag, .converter_busy_flag,
		.low_power_standby, .dac_outputs_on_flag, .board_reset_n, .fault_lamp);
	host_bus u_host_bus (.clk_sys, .pol(io_window_polarity_jumper),
		.bus_rdata, .bus_rdata_oe_n, .bus_addr, .bus_wdata, .bus_iorq_n,
		.bus_rd_n, .bus_wr_n, .bus_ioexp);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic io(input logic [3:0] ofs, input logic [7:0] d, input logic rd);
		u_host_bus.xfer({base_select_jumper, ofs}, d, rd, q);
	endtask
	task automatic rdst();
		io(OFS_BOARD_STATUS, 8'h00, 1'b1);
		chk(q, {4'h0, dog_m[0], single_polarity_flag, dac_m[0],
			converter_busy_flag, low_power_standby});
	endtask
	task automatic rst(input logic sys);
		if (sys) begin
			bus_sysreset_n <= 1'b0;
			repeat (5) @(posedge clk_sys);
			bus_sysreset_n <= 1'b1;
			repeat (8) @(posedge clk_sys);
		end else
			io(OFS_LOCAL_RESET, 8'($urandom), 1'b0);
		dac_m = 0;
		dog_m = 0;
	endtask
	initial begin
		void'($urandom(32'h056b));
		{rst_n, bus_sysreset_n, io_window_polarity_jumper} = 3'h2;
		{base_select_jumper, interval_select_shunt, nonmaskable_route_jumper,
			pushbutton_route_jumper, single_polarity_flag, converter_busy_flag,
			low_power_standby} = 10'h0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk({7'h0, fault_lamp, dac_outputs_on_flag}, 9'h0);
		for (int i = 0; i < 12; i++) begin
			{base_select_jumper, io_window_polarity_jumper, single_polarity_flag,
				converter_busy_flag, low_power_standby} <= 8'($urandom);
			dac_m = $urandom % 2;
			@(posedge clk_sys);
			io(OFS_CHANNEL_ENABLE, {6'h02, dac_m[0], 1'b0}, 1'b0);
			io(4'(i % 11), 8'($urandom), 1'b0);
			chk({8'h0, dac_outputs_on_flag}, 9'(dac_m));
			rdst();
			// the block at the complemented base nibble must stay silent
			u_host_bus.xfer({~base_select_jumper, 4'hb}, 8'h0, 1'b1, q);
			chk({8'h0, q[8]}, 9'h1);
		end
		for (int k = 0; k < 2; k++) begin
			rst(k[0]);
			rdst();
			{interval_select_shunt, nonmaskable_route_jumper,
				pushbutton_route_jumper} <= {k[0], k[0], !k[0]};
			ivl = (k ? LG : SH) * TK;
			repeat (ivl + 20) @(posedge clk_sys);
			chk({7'h0, bus_nmi_n, bus_pbreset_n}, 9'h3);
			io(OFS_CHANNEL_ENABLE, 8'h09, 1'b0);
			for (int j = 0; j < 4; j++) begin
				repeat (ivl / 2) @(posedge clk_sys);
				io(OFS_DOG_REFRESH, 8'($urandom), 1'b0);
			end
			chk({7'h0, bus_nmi_n, bus_pbreset_n}, 9'h3);
			repeat (ivl + 20) @(posedge clk_sys);
			dog_m = 1;
			chk({7'h0, bus_nmi_n, bus_pbreset_n}, {7'h0, k[0], !k[0]});
			rdst();
		end
		rst(1'b0);
		rdst();
		end_of_test();
	end
endmodule
`default_nettype wire

// [verification/host_bus.sv]
// host model: byte-wide i/o reads and writes on the card's bus pins
// assumes callers enter at a rising edge of the board clock
`default_nettype none
module host_bus (
	// clock and qualifier active level
	input  wire logic       clk_sys,
	input  wire logic       pol,
	// read path
	input  wire logic [7:0] bus_rdata,
	input  wire logic       bus_rdata_oe_n,
	// address, data, strobes
	output logic      [7:0] bus_addr,
	output logic      [7:0] bus_wdata,
	output logic            bus_iorq_n,
	output logic            bus_rd_n,
	output logic            bus_wr_n,
	output logic            bus_ioexp
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{bus_addr, bus_wdata} = 16'h0;
		{bus_iorq_n, bus_rd_n, bus_wr_n, bus_ioexp} = 4'hf;
	end
	// strobe held six clocks: card syncs pins, answers three clocks late
	task automatic xfer(input logic [7:0] a, input logic [7:0] d,
		input logic rd, output logic [8:0] q);
		bus_addr <= a;
		bus_wdata <= d;
		bus_ioexp <= pol;
		bus_iorq_n <= 1'b0;
		@(posedge clk_sys);
		bus_rd_n <= !rd;
		bus_wr_n <= rd;
		repeat (6) @(posedge clk_sys);
		q = {bus_rdata_oe_n, bus_rdata};
		{bus_rd_n, bus_wr_n} <= 2'h3;
		@(posedge clk_sys);
		bus_iorq_n <= 1'b1;
		bus_ioexp <= !pol;
		// released lines never keep the last value
		bus_addr <= ~a;
		bus_wdata <= ~d;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// [verilog/board_control_watchdog.sv]
// board control: i/o decode, status, soft reset, fault lamp, watchdog
// assumes bus strobes are asynchronous pins, each held several clocks
// How it works
// - sixteen-byte block on sixteen-byte boundary
// - four jumpers set upper address nibble
// - polarity jumper picks expansion qualifier level
// - offset 11 read returns status byte
// - status bits active high, top three zero
// - write to offset 11 soft-resets board
// - bus system reset hard-resets the board
// - any reset restores defaults, dog disabled
// - fault lamp on only during reset
// - shunt in selects 700 ms, else 11 s
// - timing starts when dog enabled
// - offset 12 write sets dog, dac enables
// - write to offset 15 restarts interval
// - expiry without refresh sets expired bit
// - timeout routed to nmi or pushbutton
// - standby bit mirrors third output port
`default_nettype none
module board_control_watchdog
	import board_ctl_pkg::*;
#(
	parameter int SHORT_TICKS_P = SHORT_TICKS,
	parameter int LONG_TICKS_P  = LONG_TICKS,
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// bus pins
	input  wire logic [7:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_iorq_n,
	input  wire logic       bus_rd_n,
	input  wire logic       bus_wr_n,
	input  wire logic       bus_ioexp,
	input  wire logic       bus_sysreset_n,
	output logic     [7:0] bus_rdata,
	output logic           bus_rdata_oe_n,
	output logic           bus_nmi_n,
	output logic           bus_pbreset_n,
	// jumpers, low when installed
	input  wire logic [3:0] base_select_jumper,
	input  wire logic       io_window_polarity_jumper,
	input  wire logic       interval_select_shunt,
	input  wire logic       nonmaskable_route_jumper,
	input  wire logic       pushbutton_route_jumper,
	// peripheral status
	input  wire logic       single_polarity_flag,
	input  wire logic       converter_busy_flag,
	input  wire logic       low_power_standby,
	// board outputs
	output logic           dac_outputs_on_flag,
	output logic           board_reset_n,
	output logic           fault_lamp
);
	timeunit 1ns;
	timeprecision 1ns;

////////////////////////////////////////////////////////////////////////
// input synchronisers
	// two stages on every pin; logic reads only the second stage
	logic [7:0] addr_meta_r;
	logic [7:0] addr_sync_r;
	logic [7:0] wdata_meta_r;
	logic [7:0] wdata_sync_r;
	logic       iorq_meta_r;
	logic       iorq_sync_r;
	logic       rd_meta_r;
	logic       rd_sync_r;
	logic       wr_meta_r;
	logic       wr_sync_r;
	logic       ioexp_meta_r;
	logic       ioexp_sync_r;
	logic       sysrst_meta_r;
	logic       sysrst_sync_r;
	logic [3:0] base_meta_r;
	logic [3:0] base_sync_r;
	logic       pol_meta_r;
	logic       pol_sync_r;
	logic       wds_meta_r;
	logic       wds_sync_r;
	logic       nmi_j_meta_r;
	logic       nmi_j_sync_r;
	logic       pb_j_meta_r;
	logic       pb_j_sync_r;
	logic       unipol_meta_r;
	logic       unipol_sync_r;
	logic       busy_meta_r;
	logic       busy_sync_r;
	logic       standby_meta_r;
	logic       standby_sync_r;

	// address and data: the host holds them steady through the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr_meta_r  <= 8'hff;
			addr_sync_r  <= 8'hff;
			wdata_meta_r <= 8'h00;
			wdata_sync_r <= 8'h00;
		end else begin
			addr_meta_r  <= bus_addr;
			addr_sync_r  <= addr_meta_r;
			wdata_meta_r <= bus_wdata;
			wdata_sync_r <= wdata_meta_r;
		end
	end

	// strobes reset inactive so no false edge follows reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			iorq_meta_r   <= 1'b1;
			iorq_sync_r   <= 1'b1;
			rd_meta_r     <= 1'b1;
			rd_sync_r     <= 1'b1;
			wr_meta_r     <= 1'b1;
			wr_sync_r     <= 1'b1;
			ioexp_meta_r  <= 1'b1;
			ioexp_sync_r  <= 1'b1;
			sysrst_meta_r <= 1'b1;
			sysrst_sync_r <= 1'b1;
		end else begin
			iorq_meta_r   <= bus_iorq_n;
			iorq_sync_r   <= iorq_meta_r;
			rd_meta_r     <= bus_rd_n;
			rd_sync_r     <= rd_meta_r;
			wr_meta_r     <= bus_wr_n;
			wr_sync_r     <= wr_meta_r;
			ioexp_meta_r  <= bus_ioexp;
			ioexp_sync_r  <= ioexp_meta_r;
			sysrst_meta_r <= bus_sysreset_n;
			sysrst_sync_r <= sysrst_meta_r;
		end
	end

	// jumpers are static but may be moved with power on
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			base_meta_r  <= 4'hf;
			base_sync_r  <= 4'hf;
			pol_meta_r   <= 1'b1;
			pol_sync_r   <= 1'b1;
			wds_meta_r   <= 1'b1;
			wds_sync_r   <= 1'b1;
			nmi_j_meta_r <= 1'b1;
			nmi_j_sync_r <= 1'b1;
			pb_j_meta_r  <= 1'b1;
			pb_j_sync_r  <= 1'b1;
		end else begin
			base_meta_r  <= base_select_jumper;
			base_sync_r  <= base_meta_r;
			pol_meta_r   <= io_window_polarity_jumper;
			pol_sync_r   <= pol_meta_r;
			wds_meta_r   <= interval_select_shunt;
			wds_sync_r   <= wds_meta_r;
			nmi_j_meta_r <= nonmaskable_route_jumper;
			nmi_j_sync_r <= nmi_j_meta_r;
			pb_j_meta_r  <= pushbutton_route_jumper;
			pb_j_sync_r  <= pb_j_meta_r;
		end
	end

	// peripheral status comes from other clock domains on the card
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			unipol_meta_r  <= 1'b0;
			unipol_sync_r  <= 1'b0;
			busy_meta_r    <= 1'b0;
			busy_sync_r    <= 1'b0;
			standby_meta_r <= 1'b0;
			standby_sync_r <= 1'b0;
		end else begin
			unipol_meta_r  <= single_polarity_flag;
			unipol_sync_r  <= unipol_meta_r;
			busy_meta_r    <= converter_busy_flag;
			busy_sync_r    <= busy_meta_r;
			standby_meta_r <= low_power_standby;
			standby_sync_r <= standby_meta_r;
		end
	end

	wire [7:0] s_addr     = addr_sync_r;
	wire [7:0] s_wdata    = wdata_sync_r;
	wire       s_iorq_n   = iorq_sync_r;
	wire       s_rd_n     = rd_sync_r;
	wire       s_wr_n     = wr_sync_r;
	wire       s_ioexp    = ioexp_sync_r;
	wire       s_sysrst_n = sysrst_sync_r;
	wire [3:0] s_base     = base_sync_r;
	wire       s_pol_j    = pol_sync_r;
	wire       s_wds      = wds_sync_r;
	wire       s_nmi_j    = nmi_j_sync_r;
	wire       s_pb_j     = pb_j_sync_r;
	wire       s_unipol   = unipol_sync_r;
	wire       s_busy     = busy_sync_r;
	wire       s_standby  = standby_sync_r;

////////////////////////////////////////////////////////////////////////
// address decode
	// removed jumper (high) matches a one bit
	wire base_hit = (s_addr[7:4] == s_base);
	// installed polarity jumper reads low: qualifier active low
	wire qual_ok  = s_pol_j ? s_ioexp : !s_ioexp;
	wire selected = !s_iorq_n && base_hit && qual_ok;
	wire [3:0] ofs = s_addr[3:0];
	wire wr_lvl   = selected && !s_wr_n;
	wire rd_lvl   = selected && !s_rd_n;

	logic wr_d_r;
	// act once per write strobe, on its leading edge
	wire wr_pulse = wr_lvl && !wr_d_r;
	wire wr_reset   = wr_pulse && ofs == OFS_LOCAL_RESET;
	wire wr_ctrl    = wr_pulse && ofs == OFS_CHANNEL_ENABLE;
	wire wr_refresh = wr_pulse && ofs == OFS_DOG_REFRESH;

////////////////////////////////////////////////////////////////////////
// reset handling
	logic [2:0] soft_cnt_r;
	logic [2:0] soft_cnt_nxt;
	wire  soft_active = soft_cnt_r != 3'h0;
	wire  local_rst   = soft_active || !s_sysrst_n;
	assign soft_cnt_nxt = wr_reset ? 3'(SOFT_RST_CYCLES) :
		(soft_active ? soft_cnt_r - 3'h1 : 3'h0);

////////////////////////////////////////////////////////////////////////
// control and watchdog
	logic        dog_en_r;
	logic        dac_en_r;
	logic        expired_r;
	logic [31:0] tick_cnt_r;
	logic [31:0] dog_cnt_r;
	wire  [31:0] dog_interval = s_wds ? 32'(LONG_TICKS_P) :
		32'(SHORT_TICKS_P);
	wire tick = tick_cnt_r == 32'(TICK_CYCLES_P - 1);
	wire dog_due = dog_en_r && tick && dog_cnt_r >= dog_interval - 32'h1;
	// a refresh or a disabled dog holds the count at zero
	wire [31:0] dog_cnt_nxt = (!dog_en_r || wr_refresh) ? 32'h0 :
		(tick ? dog_cnt_r + 32'h1 : dog_cnt_r);

	// edge detect on the decoded write strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wr_d_r <= 1'b0;
		else
			wr_d_r <= wr_lvl;
	end

	// stretch a reset-port write into a few clocks of local reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			soft_cnt_r <= 3'h0;
		else
			soft_cnt_r <= soft_cnt_nxt;
	end

	// both enables share one write, so the host must resend the dac bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dog_en_r <= CTL_RESET_VAL;
			dac_en_r <= CTL_RESET_VAL;
		end else if (local_rst) begin
			dog_en_r <= CTL_RESET_VAL;
			dac_en_r <= CTL_RESET_VAL;
		end else if (wr_ctrl) begin
			dog_en_r <= s_wdata[CTL_DOG_EN];
			dac_en_r <= s_wdata[CTL_DAC_EN];
		end
	end

	// expiry sets; only a reset clears, so software cannot hide a bark
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			expired_r <= 1'b0;
		else if (local_rst)
			expired_r <= 1'b0;
		else if (dog_due)
			expired_r <= 1'b1;
	end

	// free-running prescaler: first interval may lose up to one tick
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			tick_cnt_r <= 32'h0;
		else if (local_rst || tick)
			tick_cnt_r <= 32'h0;
		else
			tick_cnt_r <= tick_cnt_r + 32'h1;
	end

	// restart after expiry so a dead host keeps being flagged
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			dog_cnt_r <= 32'h0;
		else if (local_rst || dog_due)
			dog_cnt_r <= 32'h0;
		else
			dog_cnt_r <= dog_cnt_nxt;
	end

////////////////////////////////////////////////////////////////////////
// outputs
	wire [7:0] status_byte = {3'h0, expired_r, s_unipol, dac_en_r, s_busy,
		s_standby};
	wire fire      = expired_r;
	wire rd_status = rd_lvl && ofs == OFS_BOARD_STATUS;

	// data lines driven only for a status read inside our block
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata      <= 8'h00;
			bus_rdata_oe_n <= 1'b1;
		end else begin
			bus_rdata      <= rd_status ? status_byte : 8'h00;
			bus_rdata_oe_n <= !rd_status;
		end
	end

	// timeout routing: a pulled jumper keeps its line released
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_nmi_n     <= 1'b1;
			bus_pbreset_n <= 1'b1;
		end else begin
			bus_nmi_n     <= !(fire && !s_nmi_j);
			bus_pbreset_n <= !(fire && !s_pb_j);
		end
	end

	// lamp and board reset follow the local reset one clock late
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dac_outputs_on_flag <= 1'b0;
			board_reset_n       <= 1'b0;
			fault_lamp          <= 1'b1;
		end else begin
			dac_outputs_on_flag <= dac_en_r;
			board_reset_n       <= !local_rst;
			fault_lamp          <= local_rst;
		end
	end

endmodule
`default_nettype wire

// [verilog/board_ctl_pkg.sv]
// board control package: offsets, field positions, reset values, timing
// assumes a 50 MHz board clock
`default_nettype none
package board_ctl_pkg;
	localparam logic [3:0] OFS_BOARD_STATUS   = 4'hb;
	localparam logic [3:0] OFS_LOCAL_RESET    = 4'hb;
	localparam logic [3:0] OFS_CHANNEL_ENABLE = 4'hc;
	localparam logic [3:0] OFS_DOG_REFRESH    = 4'hf;
	// status byte fields
	localparam int STAT_DOG_EXPIRED  = 4;
	localparam int STAT_SINGLE_POL   = 3;
	localparam int STAT_DAC_ON       = 2;
	localparam int STAT_BUSY         = 1;
	localparam int STAT_STANDBY      = 0;
	// channel control fields
	localparam int CTL_DOG_EN = 0;
	localparam int CTL_DAC_EN = 1;
	localparam logic CTL_RESET_VAL = 1'b0;
	// timing
	localparam int  CLK_HZ          = 50_000_000;
	localparam int  TICK_US         = 1;
	localparam int  TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
	localparam int  SHORT_MS        = 700;
	localparam int  LONG_S          = 11;
	localparam int  SHORT_TICKS     = SHORT_MS * 1000 / TICK_US;
	localparam int  LONG_TICKS      = LONG_S * 1_000_000 / TICK_US;
	localparam int  SOFT_RST_CYCLES = 4;
endpackage
`default_nettype wire
